// File: design/prs_pkg.sv
// Shared constants and types of the packet routing switch
package prs_pkg;
	// ************************************************************
	// Character format
	// ************************************************************
	localparam int CHAR_W = 9; // Bit 8 set marks a control character
	localparam int CTRL_BIT = 8;
	localparam logic [7:0] CODE_EOP = 8'h00;
	localparam logic [7:0] CODE_EEP = 8'h01;
	// ************************************************************
	// Sizes and reset values
	// ************************************************************
	localparam int NUM_PORTS = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int TABLE_SIZE = 256;
	localparam logic [7:0] TABLE_RESET_PORT = 8'hFF; // Unused entry spills
	localparam logic TABLE_RESET_DEL = 1'b0;
	localparam logic [7:0] CAM_RESET_KEY = 8'h00;

	// Output port selection scheme
	typedef enum logic [1:0] {
		PRS_HARDWARE,
		PRS_TABLE,
		PRS_CAM
	} prs_mode_t;

	// Input port sequence
	typedef enum logic [1:0] {
		PRS_HEAD,
		PRS_WAIT,
		PRS_FORWARD,
		PRS_SPILL
	} prs_state_t;
endpackage

// File: design/prs_fifo_if.sv
// Read side of an input FIFO, between FIFO and routing matrix
`timescale 1ns/1ps
interface prs_fifo_if #(
	parameter int WIDTH = prs_pkg::CHAR_W
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// File: design/prs_fifo.sv
// Small synchronous FIFO in front of each input port
`timescale 1ns/1ps
module prs_fifo #(
	parameter int WIDTH = prs_pkg::CHAR_W,
	parameter int DEPTH = prs_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	prs_fifo_if.source rd
);
	import prs_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wrPtr_ff;
	logic [AW-1:0] rdPtr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	// Handshakes, full and empty from the count
	assign wrReady = (count_ff != FULL_CNT);
	assign rd.valid = (count_ff != '0);
	assign rd.data = mem_ff[rdPtr_ff];
	assign push = wrValid && wrReady;
	assign pop = rd.valid && rd.ready;

	// Storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem_ff[wrPtr_ff] <= wrData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wrPtr_ff <= (wrPtr_ff == LAST_IDX) ? '0 : wrPtr_ff + 1'b1;
			end
			if (pop) begin
				rdPtr_ff <= (rdPtr_ff == LAST_IDX) ? '0 : rdPtr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_no_overflow: assert property (@(posedge clock) disable iff (!rst_n)
		count_ff <= FULL_CNT && (count_ff != FULL_CNT || !wrReady))
		else $error("fifo accepts while full");
endmodule // prs_fifo

// File: design/prs_switch.sv
// Wormhole routing switch with hardware, table and CAM addressing
`timescale 1ns/1ps
// Operation
// - Link ports joined by a routing matrix; each has input and output.
// - Each packet goes from its input to the one output its address selects.
// - Only the leading data character picks the output; rest is payload.
// - Leading character: first data character after previous EOP or EEP.
// - Hardware, table and CAM addressing are all offered.
// - Hardware mode: leading character value is the output port number.
// - Table mode: leading character indexes a table holding the port number.
// - CAM mode: index of the matching CAM entry is the output port.
// - Header deletion removes exactly the leading character and nothing more.
// - In table mode a per-entry bit decides whether the header is deleted.
// - An idle selected output is allocated to the whole packet.
// - Allocated path passes each character on through a one-character output register.
// - An allocated output takes no other packet until its end marker.
// - When the input runs dry, the output pauses.
// - Output cannot send: input stalls and back-pressure reaches source.
// - A packet for a busy output waits at its input port.
// - After its packet ends, an output is free for any input.
// - Inputs waiting for the same output are arbitrated.
// - The winning input sends exactly one packet before rearbitration.
// - Arbitration repeats at each packet end of a contended output.
// - Bad destination: spill through next EOP or EEP and flag an error.
// - EEP is forwarded and ends the packet exactly like EOP.
module prs_switch #(
	parameter int NPORTS = prs_pkg::NUM_PORTS,
	parameter int DEPTH = prs_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input prs_pkg::prs_mode_t addrMode,
	input wire logic headerDelete,
	input wire logic tableWe,
	input wire logic [7:0] tableAddr,
	input wire logic [7:0] tablePort,
	input wire logic tableDelete,
	input wire logic camWe,
	input wire logic [7:0] camIndex,
	input wire logic [7:0] camKey,
	input wire logic camEnable,
	input wire logic [NPORTS-1:0] inValid,
	output logic [NPORTS-1:0] inReady,
	input wire logic [NPORTS-1:0][prs_pkg::CHAR_W-1:0] inData,
	output logic [NPORTS-1:0] outValid,
	input wire logic [NPORTS-1:0] outReady,
	output logic [NPORTS-1:0][prs_pkg::CHAR_W-1:0] outData,
	output logic [NPORTS-1:0] addrError,
	output logic [NPORTS-1:0] outBusy
);
	import prs_pkg::*;
	localparam int PW = $clog2(NPORTS);
	localparam logic [7:0] NP8 = 8'(NPORTS);

	// ************************************************************
	// Input FIFOs
	// ************************************************************
	logic [NPORTS-1:0] fifoValid;
	logic [NPORTS-1:0] pop;
	logic [NPORTS-1:0][CHAR_W-1:0] fifoData;
	logic [NPORTS-1:0] isCtrl;

	// One FIFO per input port
	for (genvar i = 0; i < NPORTS; i++) begin : g_in
		prs_fifo_if #(.WIDTH(CHAR_W)) rdIf ();
		prs_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_fifo (
			.clock(clock),
			.rst_n(rst_n),
			.wrValid(inValid[i]),
			.wrReady(inReady[i]),
			.wrData(inData[i]),
			.rd(rdIf.source)
		);
		assign fifoValid[i] = rdIf.valid;
		assign fifoData[i] = rdIf.data;
		assign rdIf.ready = pop[i];
		assign isCtrl[i] = rdIf.data[CTRL_BIT];
	end

	// ************************************************************
	// Routing table and CAM
	// ************************************************************
	logic [7:0] tblPort_ff [TABLE_SIZE];
	logic tblDel_ff [TABLE_SIZE];
	logic [7:0] camKey_ff [NPORTS];
	logic camOn_ff [NPORTS];

	// Table written from the configuration port
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < TABLE_SIZE; k++) begin
				tblPort_ff[k] <= TABLE_RESET_PORT;
				tblDel_ff[k] <= TABLE_RESET_DEL;
			end
		end else if (tableWe) begin
			tblPort_ff[tableAddr] <= tablePort;
			tblDel_ff[tableAddr] <= tableDelete;
		end
	end

	// CAM entries, one per output port
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < NPORTS; k++) begin
				camKey_ff[k] <= CAM_RESET_KEY;
				camOn_ff[k] <= 1'b0;
			end
		end else if (camWe && camIndex < NP8) begin
			camKey_ff[camIndex[PW-1:0]] <= camKey;
			camOn_ff[camIndex[PW-1:0]] <= camEnable;
		end
	end

	// ************************************************************
	// Route lookup on the leading character
	// ************************************************************
	logic [NPORTS-1:0] routeOk;
	logic [NPORTS-1:0] routeDel;
	logic [NPORTS-1:0][PW-1:0] routePort;

	// Lookup per input, from the FIFO head only
	always_comb begin
		for (int i = 0; i < NPORTS; i++) begin
			routeOk[i] = 1'b0;
			routeDel[i] = headerDelete;
			routePort[i] = '0;
			unique case (addrMode)
				PRS_HARDWARE: begin
					routeOk[i] = fifoData[i][7:0] < NP8;
					routePort[i] = fifoData[i][PW-1:0];
				end
				PRS_TABLE: begin
					routeOk[i] = tblPort_ff[fifoData[i][7:0]] < NP8;
					routePort[i] = tblPort_ff[fifoData[i][7:0]][PW-1:0];
					routeDel[i] = tblDel_ff[fifoData[i][7:0]];
				end
				PRS_CAM: begin
					for (int k = NPORTS - 1; k >= 0; k--) begin
						if (camOn_ff[k] && camKey_ff[k] == fifoData[i][7:0]) begin
							routeOk[i] = 1'b1;
							routePort[i] = PW'(k);
						end
					end
				end
				default: begin
					routeOk[i] = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Input port sequence
	// ************************************************************
	prs_state_t state_ff [NPORTS];
	logic [NPORTS-1:0][PW-1:0] dest_ff;
	logic [NPORTS-1:0] grantIn;
	logic [NPORTS-1:0] move;
	logic [NPORTS-1:0] fwdMove;
	logic [NPORTS-1:0] dropHead;

	// Head is dropped if stray marker, unroutable or deleted
	always_comb begin
		for (int i = 0; i < NPORTS; i++) begin
			dropHead[i] = isCtrl[i] || !routeOk[i] || routeDel[i];
			fwdMove[i] = (state_ff[i] == PRS_FORWARD) && move[dest_ff[i]];
			unique case (state_ff[i])
				PRS_HEAD: pop[i] = fifoValid[i] && dropHead[i];
				PRS_WAIT: pop[i] = 1'b0;
				PRS_FORWARD: pop[i] = fwdMove[i];
				PRS_SPILL: pop[i] = fifoValid[i];
			endcase
		end
	end

	// Per-input state; a marker returns to head search
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NPORTS; i++) begin
				state_ff[i] <= PRS_HEAD;
				dest_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NPORTS; i++) begin
				unique case (state_ff[i])
					PRS_HEAD: begin
						if (fifoValid[i] && !isCtrl[i]) begin
							if (!routeOk[i]) begin
								state_ff[i] <= PRS_SPILL;
							end else begin
								state_ff[i] <= PRS_WAIT;
								dest_ff[i] <= routePort[i];
							end
						end
					end
					PRS_WAIT: begin
						if (grantIn[i]) begin
							state_ff[i] <= PRS_FORWARD;
						end
					end
					PRS_FORWARD: begin
						if (fwdMove[i] && isCtrl[i]) begin
							state_ff[i] <= PRS_HEAD;
						end
					end
					PRS_SPILL: begin
						if (fifoValid[i] && isCtrl[i]) begin
							state_ff[i] <= PRS_HEAD;
						end
					end
				endcase
			end
		end
	end

	// Address error pulse, one cycle per discarded packet
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addrError <= '0;
		end else begin
			for (int i = 0; i < NPORTS; i++) begin
				addrError[i] <= (state_ff[i] == PRS_HEAD) && fifoValid[i] &&
					!isCtrl[i] && !routeOk[i];
			end
		end
	end

	// ************************************************************
	// Output ports and arbitration
	// ************************************************************
	logic [NPORTS-1:0] ownerOn_ff;
	logic [NPORTS-1:0][PW-1:0] owner_ff;
	logic [NPORTS-1:0][PW-1:0] rrLast_ff;
	logic [NPORTS-1:0][NPORTS-1:0] req;
	logic [NPORTS-1:0] anyReq;
	logic [NPORTS-1:0][PW-1:0] pick;
	logic [NPORTS-1:0] outSpace;

	// Round-robin pick starting after the last winner
	always_comb begin
		for (int o = 0; o < NPORTS; o++) begin
			anyReq[o] = 1'b0;
			pick[o] = '0;
			outSpace[o] = !outValid[o] || outReady[o];
			move[o] = ownerOn_ff[o] && fifoValid[owner_ff[o]] &&
				outSpace[o];
			for (int i = 0; i < NPORTS; i++) begin
				req[o][i] = (state_ff[i] == PRS_WAIT) && (dest_ff[i] == PW'(o));
			end
			for (int n = NPORTS; n >= 1; n--) begin
				if (req[o][PW'((32'(rrLast_ff[o]) + n) % NPORTS)]) begin
					anyReq[o] = 1'b1;
					pick[o] = PW'((32'(rrLast_ff[o]) + n) % NPORTS);
				end
			end
		end
		for (int i = 0; i < NPORTS; i++) begin
			grantIn[i] = 1'b0;
			for (int o = 0; o < NPORTS; o++) begin
				if (!ownerOn_ff[o] && anyReq[o] && pick[o] == PW'(i)) begin
					grantIn[i] = 1'b1;
				end
			end
		end
	end

	// Allocation held until the end marker leaves
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ownerOn_ff <= '0;
			owner_ff <= '0;
			rrLast_ff <= '0;
		end else begin
			for (int o = 0; o < NPORTS; o++) begin
				if (!ownerOn_ff[o]) begin
					if (anyReq[o]) begin
						ownerOn_ff[o] <= 1'b1;
						owner_ff[o] <= pick[o];
						rrLast_ff[o] <= pick[o];
					end
				end else if (move[o] && isCtrl[owner_ff[o]]) begin
					ownerOn_ff[o] <= 1'b0;
				end
			end
		end
	end

	// Output character register, refilled as the link drains it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outValid <= '0;
			outData <= '0;
		end else begin
			for (int o = 0; o < NPORTS; o++) begin
				if (move[o]) begin
					outValid[o] <= 1'b1;
					outData[o] <= fifoData[owner_ff[o]];
				end else if (outReady[o]) begin
					outValid[o] <= 1'b0;
				end
			end
		end
	end

	assign outBusy = ownerOn_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	for (genvar o = 0; o < NPORTS; o++) begin : g_chk_out
		a_end_releases: assert property (@(posedge clock)
			disable iff (!rst_n)
			move[o] && isCtrl[owner_ff[o]] |=> !ownerOn_ff[o])
			else $error("output not freed after end marker");
		a_owner_locked: assert property (@(posedge clock)
			disable iff (!rst_n)
			ownerOn_ff[o] && !(move[o] && isCtrl[owner_ff[o]]) |=>
			ownerOn_ff[o] && $stable(owner_ff[o]))
			else $error("output changed owner mid packet");
		a_out_hold: assert property (@(posedge clock) disable iff (!rst_n)
			outValid[o] && !outReady[o] |=> outValid[o] && $stable(outData[o]))
			else $error("output character lost under back-pressure");
		a_single_grant: assert property (@(posedge clock)
			disable iff (!rst_n)
			$onehot0(grantIn & req[o]))
			else $error("two inputs granted one output");
		a_rr_advance: assert property (@(posedge clock) disable iff (!rst_n)
			!ownerOn_ff[o] && anyReq[o] |=> rrLast_ff[o] == $past(pick[o]))
			else $error("round robin pointer not advanced");
	end
	for (genvar i = 0; i < NPORTS; i++) begin : g_chk_in
		a_hw_route: assert property (@(posedge clock) disable iff (!rst_n)
			state_ff[i] == PRS_HEAD && fifoValid[i] && !isCtrl[i] &&
			addrMode == PRS_HARDWARE && fifoData[i][7:0] < NP8 |=>
			state_ff[i] == PRS_WAIT && dest_ff[i] == $past(fifoData[i][PW-1:0]))
			else $error("hardware address not taken as port");
		a_delete_one: assert property (@(posedge clock) disable iff (!rst_n)
			state_ff[i] == PRS_WAIT |-> !pop[i])
			else $error("extra character removed before forwarding");
		a_spill_flag: assert property (@(posedge clock) disable iff (!rst_n)
			state_ff[i] == PRS_HEAD && fifoValid[i] && !isCtrl[i] && !routeOk[i]
			|=> addrError[i] && state_ff[i] == PRS_SPILL)
			else $error("bad address not spilled");
		a_wait_busy: assert property (@(posedge clock) disable iff (!rst_n)
			state_ff[i] == PRS_WAIT && ownerOn_ff[dest_ff[i]] |=>
			state_ff[i] == PRS_WAIT)
			else $error("packet left while output busy");
	end
endmodule // prs_switch

// File: bench/prs_link_sink.sv
// Far-end link receivers that take characters from the switch outputs
`timescale 1ns/1ps
module prs_link_sink #(
	parameter int NPORTS = prs_pkg::NUM_PORTS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [NPORTS-1:0] hold,
	input wire logic [NPORTS-1:0] outValid,
	output logic [NPORTS-1:0] outReady,
	input wire logic [NPORTS-1:0][prs_pkg::CHAR_W-1:0] outData
);
	import prs_pkg::*;
	logic [CHAR_W-1:0] rxq[NPORTS][$];
	int phase;
	// ************************************************************
	// Flow control
	// ************************************************************
	// Slow mode accepts one cycle in three, staggered per port
	initial begin
		outReady = '1;
		phase = 0;
		forever begin
			@(posedge clock);
			#1;
			phase++;
			for (int p = 0; p < NPORTS; p++) begin
				outReady[p] = !hold[p] && (!slow || (phase + p) % 3 == 0);
			end
		end
	end
	// Capture every accepted character in arrival order
	always @(posedge clock) begin
		for (int p = 0; p < NPORTS; p++) begin
			if (rst_n && outValid[p] && outReady[p]) rxq[p].push_back(outData[p]);
		end
	end
endmodule // prs_link_sink

// File: bench/tb.sv
// Self-checking testbench of the packet routing switch
`timescale 1ns/1ps
module tb;
	import prs_pkg::*;
	typedef logic [CHAR_W-1:0] prs_chars_t[$];
	localparam logic [CHAR_W-1:0] EOP = {1'b1, CODE_EOP};
	localparam logic [CHAR_W-1:0] EEP = {1'b1, CODE_EEP};
	logic clock, rst_n, headerDelete, tableWe, tableDelete, camWe, camEnable;
	logic slow;
	prs_mode_t addrMode;
	logic [7:0] tableAddr, tablePort, camIndex, camKey;
	logic [3:0] inValid, inReady, outValid, outReady, addrError, outBusy, hold;
	logic [3:0][CHAR_W-1:0] inData, outData;
	int errors, checks, spills;
	prs_switch prs_switch_i (.clock(clock), .rst_n(rst_n),
		.addrMode(addrMode), .headerDelete(headerDelete),
		.tableWe(tableWe), .tableAddr(tableAddr), .tablePort(tablePort),
		.tableDelete(tableDelete), .camWe(camWe), .camIndex(camIndex),
		.camKey(camKey), .camEnable(camEnable), .inValid(inValid),
		.inReady(inReady), .inData(inData), .outValid(outValid),
		.outReady(outReady), .outData(outData), .addrError(addrError),
		.outBusy(outBusy));
	prs_link_sink prs_link_sink_i (.clock(clock), .rst_n(rst_n),
		.slow(slow), .hold(hold), .outValid(outValid),
		.outReady(outReady), .outData(outData));
	// ************************************************************
	// Clock, monitors and helpers
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Count cycles of the address error flag on input 0
	always @(posedge clock) begin
		if (addrError[0] === 1'b1) spills++;
	end
	function automatic logic [CHAR_W-1:0] dc(input logic [7:0] v);
		return {1'b0, v};
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		chk(32'h0, 32'h1);
		end_of_test();
	endtask
	// Offer characters on one input, each held until taken
	task automatic send(input int p, input prs_chars_t cs);
		logic ok;
		foreach (cs[i]) begin
			inValid[p] = 1'b1;
			inData[p] = cs[i];
			ok = 1'b0;
			for (int n = 0; n < 600 && !ok; n++) begin
				ok = (inReady[p] === 1'b1);
				@(posedge clock);
				#1;
			end
			if (!ok) timeout();
		end
		inValid[p] = 1'b0;
	endtask
	task automatic wait_rx(input int p, input int cnt);
		for (int n = 0; n < 600 && prs_link_sink_i.rxq[p].size() < cnt; n++) begin
			@(posedge clock);
		end
		if (prs_link_sink_i.rxq[p].size() < cnt) timeout();
		repeat (8) @(posedge clock);
		#1;
	endtask
	// Compare everything received on an output, extras included
	task automatic rx_check(input int p, input prs_chars_t e);
		wait_rx(p, e.size());
		chk(prs_link_sink_i.rxq[p].size(), e.size());
		foreach (e[i]) begin
			if (i < prs_link_sink_i.rxq[p].size()) begin
				chk(prs_link_sink_i.rxq[p][i], e[i]);
			end
		end
		prs_link_sink_i.rxq[p].delete();
	endtask
	function automatic bit same(input prs_chars_t a, input prs_chars_t b);
		if (a.size() != b.size()) return 1'b0;
		foreach (a[i]) if (a[i] !== b[i]) return 1'b0;
		return 1'b1;
	endfunction
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic sc_hw_route();
		addrMode = PRS_HARDWARE;
		headerDelete = 1'b0;
		send(0, {EOP, dc(8'h02), dc(8'h03), dc(8'h01), EOP});
		rx_check(2, {dc(8'h02), dc(8'h03), dc(8'h01), EOP});
	endtask
	task automatic sc_hw_delete();
		headerDelete = 1'b1;
		send(1, {dc(8'h03), dc(8'h00), dc(8'h02), EOP});
		rx_check(3, {dc(8'h00), dc(8'h02), EOP});
		headerDelete = 1'b0;
	endtask
	task automatic sc_spill();
		spills = 0;
		send(0, {dc(8'h07), dc(8'h02), dc(8'h03), EOP, dc(8'h01), dc(8'h05),
			EEP, dc(8'h01), dc(8'h06), EOP});
		rx_check(1, {dc(8'h01), dc(8'h05), EEP, dc(8'h01), dc(8'h06),
			EOP});
		chk(prs_link_sink_i.rxq[2].size(), 0);
		chk(spills, 1);
	endtask
	// Two inputs compete for output 2 behind a slow receiver
	task automatic sc_contend();
		prs_chars_t a, a2, b, g;
		a = {dc(8'h02), dc(8'hA0), dc(8'hA1), EOP};
		a2 = {dc(8'h02), dc(8'hA2), EOP};
		b = {dc(8'h02), dc(8'hB0), EOP};
		slow = 1'b1;
		fork
			send(0, {a, a2});
			send(1, b);
		join
		wait_rx(2, 10);
		g = prs_link_sink_i.rxq[2];
		chk(same(g, {a, b, a2}) || same(g, {b, a, a2}), 1);
		prs_link_sink_i.rxq[2].delete();
		slow = 1'b0;
	endtask
	task automatic sc_backpressure();
		prs_chars_t pk;
		pk = {dc(8'h03)};
		for (int i = 0; i < 10; i++) pk.push_back(dc(8'h10 + 8'(i)));
		pk.push_back(EOP);
		hold = 4'h8;
		fork
			send(2, pk);
		join_none
		repeat (30) @(posedge clock);
		#1;
		chk(inReady[2], 1'b0);
		chk(outValid[3], 1'b1);
		chk(outBusy[3], 1'b1);
		hold = 4'h0;
		rx_check(3, pk);
		chk(outBusy[3], 1'b0);
	endtask
	task automatic sc_table();
		addrMode = PRS_TABLE;
		headerDelete = 1'b1;
		tableWe = 1'b1;
		tableAddr = 8'h05;
		tablePort = 8'h01;
		tableDelete = 1'b1;
		@(posedge clock);
		#1;
		tableAddr = 8'h06;
		tablePort = 8'h00;
		tableDelete = 1'b0;
		@(posedge clock);
		#1;
		tableWe = 1'b0;
		send(2, {dc(8'h05), dc(8'h09), EOP, dc(8'h06), dc(8'h09), EOP});
		rx_check(1, {dc(8'h09), EOP});
		rx_check(0, {dc(8'h06), dc(8'h09), EOP});
	endtask
	task automatic sc_cam();
		addrMode = PRS_CAM;
		headerDelete = 1'b1;
		camWe = 1'b1;
		camEnable = 1'b1;
		camIndex = 8'h03;
		camKey = 8'h40;
		@(posedge clock);
		#1;
		camIndex = 8'h01;
		camKey = 8'h41;
		@(posedge clock);
		#1;
		camWe = 1'b0;
		send(0, {dc(8'h40), dc(8'h01), EOP, dc(8'h41), dc(8'h02), EOP});
		rx_check(3, {dc(8'h01), EOP});
		rx_check(1, {dc(8'h02), EOP});
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		errors = 0;
		checks = 0;
		spills = 0;
		rst_n = 1'b0;
		addrMode = PRS_HARDWARE;
		{headerDelete, tableWe, tableDelete, camWe, camEnable, slow} = '0;
		{tableAddr, tablePort, camIndex, camKey} = '0;
		inValid = 4'h0;
		inData = '0;
		hold = 4'h0;
		repeat (6) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(inReady, 4'hF);
		chk(outBusy, 4'h0);
		sc_hw_route();
		sc_hw_delete();
		sc_spill();
		sc_contend();
		sc_backpressure();
		sc_table();
		sc_cam();
		end_of_test();
	end
endmodule // tb
